//--- rtl/aos_regs.sv
// Output, status, detection source, address, identity and X offset register bank
`timescale 1ns/1ps
module aos_regs
	import aos_pkg::*;
#(
	parameter logic [7:0] USER_INFO_VAL = 8'h00,
	// Arbitrary neutral identity value
	parameter logic [7:0] PART_IDENTITY_VAL = 8'h5a
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register access
	input wire aos_pkg::aos_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Measurement side
	input wire logic sample_strobe,
	input wire aos_pkg::aos_sample_t raw_sample,
	input wire aos_pkg::aos_events_t events,
	input wire aos_pkg::aos_events_t events_clear,
	input wire logic trim_parity_err,
	input wire logic self_test_req,
	input wire logic ready_pin_suppress,
	input wire logic double_pulse_mode,
	// Control outputs
	output logic twowire_disable,
	output logic self_test_en,
	output logic ready_pin,
	output logic [7:0] x_offset_trim
);
	import aos_pkg::*;

	aos_sample_t sample_r;
	logic [1:0] x_high_hold_r;
	logic [1:0] y_high_hold_r;
	logic [1:0] z_high_hold_r;
	logic sample_ready_flag_r;
	logic sample_overrun_flag_r;
	logic trim_parity_error_flag_r;
	aos_events_t source_r;
	logic [7:0] rdata_nxt;
	logic data_read;

	// Offset in half counts added to a 10-bit value in whole counts
	function automatic logic [9:0] add_trim(input logic [9:0] raw, input logic [7:0] trim);
		logic [10:0] sum;
		sum = {raw[9], raw} + {{4{trim[7]}}, trim[7:1]};
		return sum[9:0];
	endfunction

	// A read of any output byte consumes the sample
	assign data_read = req.rd && (req.addr <= AOS_Z_OUT_BYTE);

	////////////////////////////////////////////////////////////////////////
	// Sample capture with trim on the X axis

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sample_r <= '0;
		else if (sample_strobe)
		begin
			sample_r.x <= add_trim(raw_sample.x, x_offset_trim);
			sample_r.y <= raw_sample.y;
			sample_r.z <= raw_sample.z;
		end
	end

	// High bytes captured when the low byte is read, held otherwise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			x_high_hold_r <= '0;
			y_high_hold_r <= '0;
			z_high_hold_r <= '0;
		end
		else
		begin
			if (req.rd && req.addr == AOS_X_OUT_LOW)
				x_high_hold_r <= sample_r.x[9:8];
			if (req.rd && req.addr == AOS_Y_OUT_LOW)
				y_high_hold_r <= sample_r.y[9:8];
			if (req.rd && req.addr == AOS_Z_OUT_LOW)
				z_high_hold_r <= sample_r.z[9:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags; new sample wins over a clearing read

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sample_ready_flag_r <= 1'b0;
			sample_overrun_flag_r <= 1'b0;
		end
		else if (sample_strobe)
		begin
			sample_ready_flag_r <= 1'b1;
			if (sample_ready_flag_r && !data_read)
				sample_overrun_flag_r <= 1'b1;
		end
		else if (data_read)
		begin
			sample_ready_flag_r <= 1'b0;
			sample_overrun_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			trim_parity_error_flag_r <= 1'b0;
		else if (trim_parity_err)
			trim_parity_error_flag_r <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			self_test_en <= 1'b0;
		else
			self_test_en <= self_test_req && !trim_parity_error_flag_r && !trim_parity_err;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ready_pin <= 1'b0;
		else
			ready_pin <= !ready_pin_suppress && sample_ready_flag_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Detection source; set beats clear (clear driven by host write-one-then-zero)

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			source_r <= '0;
		else
			source_r <= (source_r & ~events_clear) | events;
	end

	////////////////////////////////////////////////////////////////////////
	// Writable bits

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			twowire_disable <= 1'b0;
			x_offset_trim <= AOS_ZERO_RST;
		end
		else if (req.wr)
		begin
			if (req.addr == AOS_BUS_TARGET_ADDRESS)
				twowire_disable <= req.wdata[AOS_TWOWIRE_DIS_BIT];
			else if (req.addr == AOS_X_OFFSET_LOW)
				x_offset_trim <= req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (req.addr == AOS_X_OUT_LOW)
			rdata_nxt = sample_r.x[7:0];
		else if (req.addr == AOS_X_OUT_HIGH)
			rdata_nxt = {6'h00, x_high_hold_r};
		else if (req.addr == AOS_Y_OUT_LOW)
			rdata_nxt = sample_r.y[7:0];
		else if (req.addr == AOS_Y_OUT_HIGH)
			rdata_nxt = {6'h00, y_high_hold_r};
		else if (req.addr == AOS_Z_OUT_LOW)
			rdata_nxt = sample_r.z[7:0];
		else if (req.addr == AOS_Z_OUT_HIGH)
			rdata_nxt = {6'h00, z_high_hold_r};
		else if (req.addr == AOS_X_OUT_BYTE)
			rdata_nxt = sample_r.x[9:2];
		else if (req.addr == AOS_Y_OUT_BYTE)
			rdata_nxt = sample_r.y[9:2];
		else if (req.addr == AOS_Z_OUT_BYTE)
			rdata_nxt = sample_r.z[9:2];
		else if (req.addr == AOS_SAMPLE_STATUS)
			rdata_nxt = {5'h00, trim_parity_error_flag_r, sample_overrun_flag_r, sample_ready_flag_r};
		else if (req.addr == AOS_EVENT_SOURCE)
			rdata_nxt = {source_r.level, double_pulse_mode ? 3'h0 : source_r.pulse,
				source_r.irq2, source_r.irq1};
		else if (req.addr == AOS_BUS_TARGET_ADDRESS)
			rdata_nxt = {twowire_disable, AOS_TARGET_ADDR_RST};
		else if (req.addr == AOS_USER_INFO)
			rdata_nxt = USER_INFO_VAL;
		else if (req.addr == AOS_PART_IDENTITY)
			rdata_nxt = PART_IDENTITY_VAL;
		else if (req.addr == AOS_X_OFFSET_LOW)
			rdata_nxt = x_offset_trim;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence low_x_read_s;
		req.rd && req.addr == AOS_X_OUT_LOW;
	endsequence

	sequence low_y_read_s;
		req.rd && req.addr == AOS_Y_OUT_LOW;
	endsequence

	sequence low_z_read_s;
		req.rd && req.addr == AOS_Z_OUT_LOW;
	endsequence

	sequence high_x_read_s;
		req.rd && req.addr == AOS_X_OUT_HIGH;
	endsequence

	// Low byte, one idle cycle, then the matching high byte
	sequence x_pair_read_s;
		low_x_read_s ##1 !req.rd ##1 high_x_read_s;
	endsequence

	x_high_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		low_x_read_s |=> x_high_hold_r == $past(sample_r.x[9:8]))
		else $error("x high byte not frozen");

	y_high_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		low_y_read_s |=> y_high_hold_r == $past(sample_r.y[9:8]))
		else $error("y high byte not frozen");

	z_high_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		low_z_read_s |=> z_high_hold_r == $past(sample_r.z[9:8]))
		else $error("z high byte not frozen");

	high_upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_X_OUT_HIGH |=> rvalid && rdata[7:2] == 6'h00)
		else $error("high byte upper bits not zero");

	ready_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		sample_strobe |=> sample_ready_flag_r)
		else $error("ready flag not set");

	overrun_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		sample_strobe && sample_ready_flag_r && !data_read |=> sample_overrun_flag_r)
		else $error("overrun not flagged");

	parity_blocks_test_a: assert property (@(posedge clk) disable iff (sys_rst)
		trim_parity_error_flag_r |=> !self_test_en)
		else $error("self test with parity error");

	source_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		events.irq1 |=> source_r.irq1)
		else $error("irq flag lost");

	addr_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_BUS_TARGET_ADDRESS |=> rdata[6:0] == AOS_TARGET_ADDR_RST)
		else $error("target address changed");

	ready_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
		ready_pin_suppress |=> !ready_pin)
		else $error("ready on pin while suppressed");

	x_pair_coherent_a: assert property (@(posedge clk) disable iff (sys_rst)
		x_pair_read_s |=> rdata[1:0] == $past(sample_r.x[9:8], 3))
		else $error("x high byte not from the low byte sample");

	upper_bits_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && (req.addr == AOS_Y_OUT_HIGH || req.addr == AOS_Z_OUT_HIGH) |=> rdata[7:2] == 6'h00)
		else $error("y or z high byte upper bits not zero");

	x_byte_match_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_X_OUT_BYTE |=> rdata == $past(sample_r.x[9:2]))
		else $error("x byte output wrong");

	y_byte_match_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_Y_OUT_BYTE |=> rdata == $past(sample_r.y[9:2]))
		else $error("y byte output wrong");

	z_byte_match_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_Z_OUT_BYTE |=> rdata == $past(sample_r.z[9:2]))
		else $error("z byte output wrong");

	ready_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		data_read && !sample_strobe |=> !sample_ready_flag_r && !sample_overrun_flag_r)
		else $error("sample flags not cleared by read");

	level_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
		events.level != 3'h0 |=> (source_r.level & $past(events.level)) == $past(events.level))
		else $error("level event lost");

	pulse_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
		events.pulse != 3'h0 |=> (source_r.pulse & $past(events.pulse)) == $past(events.pulse))
		else $error("pulse event lost");

	pulse_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_EVENT_SOURCE && double_pulse_mode |=> rdata[4:2] == 3'h0)
		else $error("pulse flags shown in double pulse mode");

	irq2_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		events.irq2 |=> source_r.irq2)
		else $error("second irq flag lost");

	twowire_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == AOS_BUS_TARGET_ADDRESS |=> twowire_disable == $past(req.wdata[AOS_TWOWIRE_DIS_BIT]))
		else $error("two-wire disable not written");

	user_info_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_USER_INFO |=> rdata == USER_INFO_VAL)
		else $error("user info byte wrong");

	identity_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == AOS_PART_IDENTITY |=> rdata == PART_IDENTITY_VAL)
		else $error("identity byte wrong");

	offset_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == AOS_X_OFFSET_LOW |=> x_offset_trim == $past(req.wdata))
		else $error("offset trim not written");

	// Signed half-count trim, rounded toward minus infinity
	trim_applied_a: assert property (@(posedge clk) disable iff (sys_rst)
		sample_strobe |=> $signed(sample_r.x) == $signed($past(raw_sample.x)) + ($signed($past(x_offset_trim)) >>> 1))
		else $error("offset trim not applied to x");

	flags_reset_a: assert property (@(posedge clk)
		sys_rst |=> !sample_ready_flag_r && !sample_overrun_flag_r && !trim_parity_error_flag_r && source_r == '0)
		else $error("flags not cleared by reset");

	write_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr != AOS_BUS_TARGET_ADDRESS && req.addr != AOS_X_OFFSET_LOW
		|=> $stable(twowire_disable) && $stable(x_offset_trim))
		else $error("write to read-only register took effect");

	ready_pin_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ready_pin_suppress && sample_ready_flag_r |=> ready_pin)
		else $error("ready not routed to pin");

endmodule

//--- rtl/aos_pkg.sv
// Package: register map, field positions, reset values and carriers for the output/status bank
package aos_pkg;

	// Register offsets
	localparam logic [4:0] AOS_X_OUT_LOW = 5'h00;
	localparam logic [4:0] AOS_X_OUT_HIGH = 5'h01;
	localparam logic [4:0] AOS_Y_OUT_LOW = 5'h02;
	localparam logic [4:0] AOS_Y_OUT_HIGH = 5'h03;
	localparam logic [4:0] AOS_Z_OUT_LOW = 5'h04;
	localparam logic [4:0] AOS_Z_OUT_HIGH = 5'h05;
	localparam logic [4:0] AOS_X_OUT_BYTE = 5'h06;
	localparam logic [4:0] AOS_Y_OUT_BYTE = 5'h07;
	localparam logic [4:0] AOS_Z_OUT_BYTE = 5'h08;
	localparam logic [4:0] AOS_SAMPLE_STATUS = 5'h09;
	localparam logic [4:0] AOS_EVENT_SOURCE = 5'h0a;
	localparam logic [4:0] AOS_BUS_TARGET_ADDRESS = 5'h0d;
	localparam logic [4:0] AOS_USER_INFO = 5'h0e;
	localparam logic [4:0] AOS_PART_IDENTITY = 5'h0f;
	localparam logic [4:0] AOS_X_OFFSET_LOW = 5'h10;

	// Field positions
	localparam int AOS_READY_BIT = 0;
	localparam int AOS_OVERRUN_BIT = 1;
	localparam int AOS_PARITY_BIT = 2;
	localparam int AOS_TWOWIRE_DIS_BIT = 7;

	// Reset values
	localparam logic [7:0] AOS_ZERO_RST = 8'h00;
	localparam logic [6:0] AOS_TARGET_ADDR_RST = 7'h1d;

	// One acceleration sample for three axes
	typedef struct packed {
		logic [9:0] x;
		logic [9:0] y;
		logic [9:0] z;
	} aos_sample_t;

	// Detection events from the detector
	typedef struct packed {
		logic [2:0] level;
		logic [2:0] pulse;
		logic irq2;
		logic irq1;
	} aos_events_t;

	// Register access from the serial front end
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} aos_req_t;

endpackage

//--- bench/aos_host.sv
// Host model: register reads and writes into the bank
`timescale 1ns/1ps
module aos_host
	import aos_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register access
	output aos_pkg::aos_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial req = '0;
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Released address and data lines show inverted values, never the last ones
	task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output bit ok);
		@(posedge clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
		ok = 1'b0;
		d = 8'h00;
		for (int n = 0; n < 4 && !ok; n++)
		begin
			#1;
			if (rvalid === 1'b1)
			begin
				ok = 1'b1;
				d = rdata;
			end
			else
				@(posedge clk);
		end
	endtask
endmodule

//--- bench/accel_output_status_regs_tb.sv
// Self-checking bench for the output and status register bank
`timescale 1ns/1ps
module accel_output_status_regs_tb;
	import aos_pkg::*;
	localparam logic [9:0] BX = 10'h155, BY = 10'h2c7, BZ = 10'h0f0;
	localparam logic [9:0] CX = 10'h2a5, CY = 10'h17e, CZ = 10'h3ff;
	logic clk, sys_rst, rvalid, sample_strobe, trim_parity_err, self_test_req;
	logic ready_pin_suppress, double_pulse_mode, twowire_disable, self_test_en, ready_pin;
	logic [7:0] rdata, x_offset_trim;
	aos_req_t req;
	aos_sample_t raw_sample;
	aos_events_t events, events_clear;
	int error_cnt, cmp_count;
	logic [7:0] rst_tbl [0:31];
	// Arbitrary one-time storage values
	aos_regs #(.USER_INFO_VAL(8'h3c), .PART_IDENTITY_VAL(8'hc3)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.req(req), .rdata(rdata), .rvalid(rvalid), .sample_strobe(sample_strobe), .raw_sample(raw_sample),
		.events(events), .events_clear(events_clear), .trim_parity_err(trim_parity_err),
		.self_test_req(self_test_req), .ready_pin_suppress(ready_pin_suppress),
		.double_pulse_mode(double_pulse_mode), .twowire_disable(twowire_disable),
		.self_test_en(self_test_en), .ready_pin(ready_pin), .x_offset_trim(x_offset_trim));
	aos_host i_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		i_host.read_reg(a, d, ok);
		if (!ok)
		begin
			error_cnt++;
			$display("unexpected at %0t: no read answer at %h", $time, a);
			give_verdict();
		end
		else
			chk(d, exp);
	endtask
	task automatic strobe(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
		@(posedge clk);
		raw_sample <= '{x: x, y: y, z: z};
		sample_strobe <= 1'b1;
		@(posedge clk);
		sample_strobe <= 1'b0;
		raw_sample <= ~raw_sample;
	endtask
	task automatic ev(input logic [7:0] e, input bit clr);
		@(posedge clk);
		if (clr)
			events_clear <= aos_events_t'(e);
		else
			events <= aos_events_t'(e);
		@(posedge clk);
		events <= '0;
		events_clear <= '0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{sys_rst, sample_strobe, trim_parity_err, ready_pin_suppress, double_pulse_mode} = 5'h10;
		self_test_req = 1'b1;
		raw_sample = '0;
		events = '0;
		events_clear = '0;
		foreach (rst_tbl[i]) rst_tbl[i] = 8'h00;
		rst_tbl[13] = 8'h1d;
		rst_tbl[14] = 8'h3c;
		rst_tbl[15] = 8'hc3;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 32; a++)
			if (a != 13 && a != 16) i_host.write_reg(5'(a), 8'hff);
		for (int a = 0; a < 32; a++) rd(5'(a), rst_tbl[a]);
		chk(self_test_en, 8'h01);
		$display("test reset values done");
		i_host.write_reg(5'h0d, 8'hff);
		rd(5'h0d, 8'h9d);
		chk(twowire_disable, 8'h01);
		i_host.write_reg(5'h0d, 8'h00);
		rd(5'h0d, 8'h1d);
		chk(twowire_disable, 8'h00);
		$display("test address register done");
		strobe(BX, BY, BZ);
		rd(5'h09, 8'h01);
		chk(ready_pin, 8'h01);
		@(posedge clk) ready_pin_suppress <= 1'b1;
		repeat (3) @(posedge clk);
		chk(ready_pin, 8'h00);
		ready_pin_suppress <= 1'b0;
		strobe(BX, BY, BZ);
		rd(5'h09, 8'h03);
		rd(5'h02, BY[7:0]);
		rd(5'h09, 8'h00);
		strobe(CX, CY, CZ);
		rd(5'h03, {6'h00, BY[9:8]});
		rd(5'h00, CX[7:0]);
		rd(5'h01, {6'h00, CX[9:8]});
		rd(5'h04, CZ[7:0]);
		rd(5'h05, {6'h00, CZ[9:8]});
		rd(5'h06, CX[9:2]);
		rd(5'h07, CY[9:2]);
		rd(5'h08, CZ[9:2]);
		rd(5'h00, CX[7:0]);
		strobe(BX, BY, BZ);
		rd(5'h01, {6'h00, CX[9:8]});
		$display("test samples done");
		i_host.write_reg(5'h10, 8'hf9);
		rd(5'h10, 8'hf9);
		chk(x_offset_trim, 8'hf9);
		strobe(10'h010, BY, BZ);
		rd(5'h00, 8'h0c);
		rd(5'h01, 8'h00);
		i_host.write_reg(5'h10, 8'h08);
		strobe(10'h3fe, BY, BZ);
		rd(5'h00, 8'h02);
		rd(5'h01, 8'h00);
		$display("test offset trim done");
		@(posedge clk) trim_parity_err <= 1'b1;
		@(posedge clk) trim_parity_err <= 1'b0;
		repeat (2) @(posedge clk);
		chk(self_test_en, 8'h00);
		rd(5'h09, 8'h04);
		$display("test parity done");
		for (int k = 0; k < 2; k++)
		begin
			ev(k ? 8'h55 : 8'haa, 1'b0);
			rd(5'h0a, k ? 8'h55 : 8'haa);
			ev(8'hff, 1'b1);
			rd(5'h0a, 8'h00);
		end
		@(posedge clk) double_pulse_mode <= 1'b1;
		ev(8'hff, 1'b0);
		rd(5'h0a, 8'he3);
		$display("test detection source done");
		i_host.write_reg(5'h0d, 8'h80);
		strobe(CX, CY, CZ);
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(5'h09, 8'h00);
		rd(5'h0a, 8'h00);
		rd(5'h0d, 8'h1d);
		rd(5'h10, 8'h00);
		rd(5'h03, 8'h00);
		chk(self_test_en, 8'h01);
		chk(twowire_disable, 8'h00);
		chk(ready_pin, 8'h00);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
